// ### src/ccr_pkg.sv
// constants for the converter control register bank
package ccr_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CCR_ADDR_STEP_DOWN_TWO_CONTROL = 8'h06;
  localparam logic [7:0] CCR_ADDR_BUCK_BOOST_CONTROL = 8'h07;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CCR_RSVD_BIT = 7;
  localparam int CCR_SD_EN_BIT = 6;
  localparam int CCR_SD_PWM_BIT = 5;
  localparam int CCR_BB_PWM_BIT = 6;
  localparam int CCR_BB_EN_BIT = 5;
  localparam int CCR_VSEL_MSB = 4;
  localparam int CCR_VSEL_W = 5;

  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic CCR_SD_EN_RST = 1'b1;
  localparam logic CCR_SD_PWM_RST = 1'b0;
  localparam logic CCR_BB_EN_RST = 1'b1;
  localparam logic CCR_BB_PWM_RST = 1'b0;
  localparam logic [4:0] CCR_VSEL_DEF_SD = 5'h0F;
  localparam logic [4:0] CCR_VSEL_DEF_BB = 5'h1F;
  localparam logic [4:0] CCR_VSEL_OFF = 5'h00;

  // ----------------------------------------------------------------
  // voltage code classes for the step-down converter
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    CCR_SD_EXT_FB = 2'h0,
    CCR_SD_STEPPED = 2'h1,
    CCR_SD_TOP = 2'h3
  } ccr_sd_mode_type;

endpackage : ccr_pkg

// ### src/ccr_field.sv
// one writable control field with byte-write update
`timescale 1ns/1ps
module ccr_field
  import ccr_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  output logic [WIDTH-1:0] value
);

  logic [WIDTH-1:0] val_ff;
  wire logic [WIDTH-1:0] nxt_val = wr_en ? wr_data : val_ff;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      val_ff <= RST_VAL;
    else
      val_ff <= nxt_val;
  end

  assign value = val_ff;

endmodule : ccr_field

// ### src/ccr_converter_control_regs.sv
// register bank controlling the io step-down and buck-boost converters
//
// Summary of operation
// - offset 06h bit 6 enables the io step-down converter and resets to 1.
// - offset 06h bit 5 forces fixed-frequency modulation when set, automatic when 0, reset 0.
// - step-down code 00h means external feedback, 01h-0Fh 1.8-3.2 V, any 1xh 3.3 V.
// - offset 07h bit 6 forces fixed-frequency modulation when set, reset 0.
// - the buck-boost comes up enabled at power-on without software action.
// - the buck-boost is off whenever its voltage code is zero, whatever the enable.
// - while the buck-boost is off with a nonzero voltage code its output pull-down control is asserted.
// - with a zero voltage code the pull-down control is released.
// - the buck-boost code reset value is a factory default parameter.
// - both registers are reached through the serial control interface write/read port.
`timescale 1ns/1ps
module ccr_converter_control_regs
  import ccr_pkg::*;
#(
  parameter logic [4:0] SD_VSEL_DEFAULT = CCR_VSEL_DEF_SD,
  parameter logic [4:0] BB_VSEL_DEFAULT = CCR_VSEL_DEF_BB
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic sd_enable,
  output logic sd_force_pwm,
  output logic [4:0] sd_vsel,
  output logic sd_ext_feedback,
  output logic bb_enable,
  output logic bb_force_pwm,
  output logic [4:0] bb_vsel,
  output logic bb_pulldown
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire logic sel_sd = (reg_addr == CCR_ADDR_STEP_DOWN_TWO_CONTROL);
  wire logic sel_bb = (reg_addr == CCR_ADDR_BUCK_BOOST_CONTROL);
  wire logic wr_sd = reg_wr & sel_sd;
  wire logic wr_bb = reg_wr & sel_bb;

  // ----------------------------------------------------------------
  // step-down register fields
  // ----------------------------------------------------------------
  logic [6:0] sd_reg;

  ccr_field #(.WIDTH(1), .RST_VAL(CCR_SD_EN_RST)) u_sd_en
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(wr_sd),
    .wr_data(reg_wdata[CCR_SD_EN_BIT]),
    .value(sd_reg[CCR_SD_EN_BIT])
  );

  ccr_field #(.WIDTH(1), .RST_VAL(CCR_SD_PWM_RST)) u_sd_pwm
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(wr_sd),
    .wr_data(reg_wdata[CCR_SD_PWM_BIT]),
    .value(sd_reg[CCR_SD_PWM_BIT])
  );

  ccr_field #(.WIDTH(CCR_VSEL_W), .RST_VAL(SD_VSEL_DEFAULT)) u_sd_vsel
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(wr_sd),
    .wr_data(reg_wdata[CCR_VSEL_MSB:0]),
    .value(sd_reg[CCR_VSEL_MSB:0])
  );

  // ----------------------------------------------------------------
  // buck-boost register fields
  // ----------------------------------------------------------------
  logic [6:0] bb_reg;

  ccr_field #(.WIDTH(1), .RST_VAL(CCR_BB_EN_RST)) u_bb_en
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(wr_bb),
    .wr_data(reg_wdata[CCR_BB_EN_BIT]),
    .value(bb_reg[CCR_BB_EN_BIT])
  );

  ccr_field #(.WIDTH(1), .RST_VAL(CCR_BB_PWM_RST)) u_bb_pwm
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(wr_bb),
    .wr_data(reg_wdata[CCR_BB_PWM_BIT]),
    .value(bb_reg[CCR_BB_PWM_BIT])
  );

  ccr_field #(.WIDTH(CCR_VSEL_W), .RST_VAL(BB_VSEL_DEFAULT)) u_bb_vsel
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(wr_bb),
    .wr_data(reg_wdata[CCR_VSEL_MSB:0]),
    .value(bb_reg[CCR_VSEL_MSB:0])
  );

  // ----------------------------------------------------------------
  // converter control derivation
  // ----------------------------------------------------------------
  ccr_sd_mode_type sd_mode;
  assign sd_mode = (sd_reg[CCR_VSEL_MSB:0] == CCR_VSEL_OFF) ? CCR_SD_EXT_FB :
                   sd_reg[CCR_VSEL_MSB] ? CCR_SD_TOP : CCR_SD_STEPPED;
  // any 1xh code collapses to the 3.3 V setting
  wire logic [4:0] sd_vsel_eff = (sd_mode == CCR_SD_TOP) ? 5'h10 :
                                 sd_reg[CCR_VSEL_MSB:0];
  wire logic bb_code_zero = (bb_reg[CCR_VSEL_MSB:0] == CCR_VSEL_OFF);
  wire logic bb_on = bb_reg[CCR_BB_EN_BIT] & ~bb_code_zero;
  // a zero code leaves the output floating, so only a real off pulls it down
  wire logic bb_pd = ~bb_on & ~bb_code_zero;

  // read mux, bit 7 held at zero
  wire logic [7:0] rd_mux = sel_sd ? {1'b0, sd_reg} :
                            sel_bb ? {1'b0, bb_reg} : 8'h00;

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  logic [7:0] rdata_ff;
  logic rvalid_ff;
  logic sd_en_ff;
  logic sd_pwm_ff;
  logic [4:0] sd_vsel_ff;
  logic sd_ext_ff;
  logic bb_en_ff;
  logic bb_pwm_ff;
  logic [4:0] bb_vsel_ff;
  logic bb_pd_ff;

  // ----------------------------------------------------------------
  // next values of the output flops
  // ----------------------------------------------------------------
  // read data holds until the next read strobe
  wire logic [7:0] nxt_rdata = reg_rd ? rd_mux : rdata_ff;
  wire logic nxt_rvalid = reg_rd;
  wire logic nxt_sd_en = sd_reg[CCR_SD_EN_BIT];
  wire logic nxt_sd_pwm = sd_reg[CCR_SD_PWM_BIT];
  wire logic [4:0] nxt_sd_vsel = sd_vsel_eff;
  wire logic nxt_sd_ext = (sd_mode == CCR_SD_EXT_FB);
  wire logic nxt_bb_en = bb_on;
  wire logic nxt_bb_pwm = bb_reg[CCR_BB_PWM_BIT];
  wire logic [4:0] nxt_bb_vsel = bb_reg[CCR_VSEL_MSB:0];
  wire logic nxt_bb_pd = bb_pd;

  // ----------------------------------------------------------------
  // read answer flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rdata_ff <= 8'h00;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= nxt_rvalid;
    end
  end

  // ----------------------------------------------------------------
  // step-down output flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sd_en_ff <= 1'b0;
    end
    else
    begin
      sd_en_ff <= nxt_sd_en;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sd_pwm_ff <= 1'b0;
    end
    else
    begin
      sd_pwm_ff <= nxt_sd_pwm;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sd_vsel_ff <= 5'h00;
    end
    else
    begin
      sd_vsel_ff <= nxt_sd_vsel;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sd_ext_ff <= 1'b0;
    end
    else
    begin
      sd_ext_ff <= nxt_sd_ext;
    end
  end

  // ----------------------------------------------------------------
  // buck-boost output flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      bb_en_ff <= 1'b0;
    end
    else
    begin
      bb_en_ff <= nxt_bb_en;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      bb_pwm_ff <= 1'b0;
    end
    else
    begin
      bb_pwm_ff <= nxt_bb_pwm;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      bb_vsel_ff <= 5'h00;
    end
    else
    begin
      bb_vsel_ff <= nxt_bb_vsel;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      bb_pd_ff <= 1'b0;
    end
    else
    begin
      bb_pd_ff <= nxt_bb_pd;
    end
  end

  // ----------------------------------------------------------------
  // output ports
  // ----------------------------------------------------------------
  assign reg_rdata = rdata_ff;
  assign reg_rvalid = rvalid_ff;
  assign sd_enable = sd_en_ff;
  assign sd_force_pwm = sd_pwm_ff;
  assign sd_vsel = sd_vsel_ff;
  assign sd_ext_feedback = sd_ext_ff;
  assign bb_enable = bb_en_ff;
  assign bb_force_pwm = bb_pwm_ff;
  assign bb_vsel = bb_vsel_ff;
  assign bb_pulldown = bb_pd_ff;

endmodule : ccr_converter_control_regs

// ### bench/ccr_regs_sva.sv
// concurrent checks on the converter control register bank ports
`timescale 1ns/1ps
module ccr_regs_sva
  import ccr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic sd_enable,
  input wire logic sd_force_pwm,
  input wire logic [4:0] sd_vsel,
  input wire logic sd_ext_feedback,
  input wire logic bb_enable,
  input wire logic bb_force_pwm,
  input wire logic [4:0] bb_vsel,
  input wire logic bb_pulldown
);
  logic [7:0] wd1_ff;
  logic [7:0] wd2_ff;
  wire sd_wr = reg_wr && reg_addr == CCR_ADDR_STEP_DOWN_TWO_CONTROL;
  wire bb_wr = reg_wr && reg_addr == CCR_ADDR_BUCK_BOOST_CONTROL;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // write data as it was two edges back
  always_ff @(posedge clk_sys)
  begin
    wd1_ff <= reg_wdata;
    wd2_ff <= wd1_ff;
  end
  rd_answer_a: assert property (1 |=> reg_rvalid == $past(reg_rd))
    else $error("read answer timing wrong");
  rsvd_zero_a: assert property (reg_rvalid |-> reg_rdata[7] == 1'b0)
    else $error("reserved bit read nonzero");
  sd_write_a: assert property (sd_wr |-> ##2 {sd_enable, sd_force_pwm} == wd2_ff[6:5])
    else $error("step-down enable or pwm wrong");
  sd_code_a: assert property (sd_wr |-> ##2 sd_vsel == (wd2_ff[4] ? 5'h10 : wd2_ff[4:0]))
    else $error("step-down code wrong");
  sd_extfb_a: assert property (!$past(rst) |-> sd_ext_feedback == (sd_vsel == 5'h00))
    else $error("external feedback flag wrong");
  bb_write_a: assert property (bb_wr |-> ##2 {bb_force_pwm, bb_vsel} == {wd2_ff[6], wd2_ff[4:0]})
    else $error("buck-boost pwm or code wrong");
  bb_enable_a: assert property (bb_wr |-> ##2 bb_enable == (wd2_ff[5] && wd2_ff[4:0] != 5'h00))
    else $error("buck-boost enable wrong");
  bb_zero_a: assert property (bb_vsel == 5'h00 |-> !bb_enable && !bb_pulldown)
    else $error("zero code not off or pull-down on");
  bb_pull_a: assert property (bb_vsel != 5'h00 |-> bb_pulldown == !bb_enable)
    else $error("pull-down not tied to off state");
endmodule : ccr_regs_sva

bind ccr_converter_control_regs ccr_regs_sva u_sva (.clk_sys(clk_sys), .rst(rst),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sd_enable(sd_enable),
  .sd_force_pwm(sd_force_pwm), .sd_vsel(sd_vsel), .sd_ext_feedback(sd_ext_feedback),
  .bb_enable(bb_enable), .bb_force_pwm(bb_force_pwm), .bb_vsel(bb_vsel),
  .bb_pulldown(bb_pulldown));

// ### bench/tb_converter_control_regs.sv
// self-checking bench for the converter control register bank
`timescale 1ns/1ps
`define CCR_CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_total++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module tb_converter_control_regs;
  import ccr_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic reg_rvalid, sd_enable, sd_force_pwm, sd_ext_feedback, bb_enable, bb_force_pwm;
  logic bb_pulldown;
  logic [4:0] sd_vsel, bb_vsel;
  int err_total = 0, comparisons = 0;
  always #2 clk_sys = ~clk_sys;
  ccr_converter_control_regs #(.SD_VSEL_DEFAULT(CCR_VSEL_DEF_SD),
    .BB_VSEL_DEFAULT(CCR_VSEL_DEF_BB)) dut (.clk_sys(clk_sys), .rst(rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sd_enable(sd_enable),
    .sd_force_pwm(sd_force_pwm), .sd_vsel(sd_vsel), .sd_ext_feedback(sd_ext_feedback),
    .bb_enable(bb_enable), .bb_force_pwm(bb_force_pwm), .bb_vsel(bb_vsel),
    .bb_pulldown(bb_pulldown));
  // write, then wait until the output flops show it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    `CCR_CHK(reg_rvalid, 1'b1)
    `CCR_CHK(reg_rdata, e)
  endtask : rd
  task automatic t_reset;
    `CCR_CHK(sd_enable, 1'b1)
    `CCR_CHK(sd_force_pwm, 1'b0)
    `CCR_CHK(sd_vsel, CCR_VSEL_DEF_SD)
    `CCR_CHK({bb_enable, bb_force_pwm, bb_pulldown}, 3'b100)
    `CCR_CHK(bb_vsel, CCR_VSEL_DEF_BB)
    rd(8'h06, {3'b010, CCR_VSEL_DEF_SD});
    rd(8'h07, {3'b001, CCR_VSEL_DEF_BB});
    $display("t_reset done");
  endtask : t_reset
  task automatic t_sd;
    logic [4:0] codes [5] = '{5'h00, 5'h01, 5'h0F, 5'h10, 5'h1F};
    for (int i = 0; i < 5; i++)
    begin
      wr(8'h06, {1'b1, i[0], ~i[0], codes[i]});
      `CCR_CHK({sd_enable, sd_force_pwm}, {i[0], ~i[0]})
      `CCR_CHK(sd_vsel, codes[i][4] ? 5'h10 : codes[i])
      `CCR_CHK(sd_ext_feedback, codes[i] == 5'h00)
      rd(8'h06, {1'b0, i[0], ~i[0], codes[i]});
    end
    $display("t_sd done");
  endtask : t_sd
  task automatic t_bb;
    logic [7:0] tbl [4] = '{8'h85, 8'h25, 8'hE0, 8'h5F};
    logic en;
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h07, tbl[i]);
      en = tbl[i][5] && tbl[i][4:0] != 5'h00;
      `CCR_CHK(bb_enable, en)
      `CCR_CHK(bb_pulldown, !en && tbl[i][4:0] != 5'h00)
      `CCR_CHK({bb_force_pwm, bb_vsel}, {tbl[i][6], tbl[i][4:0]})
      rd(8'h07, tbl[i] & 8'h7F);
    end
    $display("t_bb done");
  endtask : t_bb
  task automatic t_unmapped;
    wr(8'h08, 8'hFF);
    rd(8'h08, 8'h00);
    rd(8'h06, 8'h3F);
    rd(8'h07, 8'h5F);
    $display("t_unmapped done");
  endtask : t_unmapped
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    t_reset();
    t_sd();
    t_bb();
    t_unmapped();
    end_sim();
  end
  // about 80 cycles expected, cut off well beyond
  initial
  begin
    #20000;
    err_total++;
    end_sim();
  end
endmodule : tb_converter_control_regs
